/* File: hw/apcb_pkg.sv */
// constants and types shared by the audio path configuration bank
package apcb_pkg;

	// ==========================================================
	// register geometry
	localparam int WORD_W = 16;
	localparam logic [1:0] SEL_WORD_A = 2'h0;
	localparam logic [1:0] SEL_WORD_B = 2'h1;
	localparam logic [1:0] SEL_WORD_C = 2'h2;

	// reset values: every optional stage except the second mixer starts powered down
	localparam logic [15:0] RST_WORD_A = 16'h0101;
	localparam logic [15:0] RST_WORD_B = 16'h0183;
	localparam logic [15:0] RST_WORD_C = 16'h0000;

	// ==========================================================
	// field positions in path_config_word_a
	localparam int A_ATTENUATOR_PD = 0;
	localparam int A_OUT_AMP_LO    = 1;
	localparam int A_OUTPUT_MUX_LO = 3;
	localparam int A_COMPRESSION   = 7;
	localparam int A_OSC_PD        = 8;
	localparam int A_INPUT_SRC     = 9;

	// field positions in path_config_word_b
	localparam int B_GAIN_AMP_PD   = 0;
	localparam int B_LOWPASS_PD    = 1;
	localparam int B_RATE_LO       = 2;
	localparam int B_FILTER_SEL    = 4;
	localparam int B_MIX2_SRC_LO   = 5;
	localparam int B_MIX1_SRC_LO   = 7;
	localparam int B_MIX1_MUX_LO   = 9;
	localparam int B_ATTEN_LO      = 11;
	localparam int B_VOL_MUX_LO    = 14;

	// ==========================================================
	// field encodings
	localparam logic [1:0] MIX1_MUX_CODEC   = 2'h0;
	localparam logic [1:0] MIX1_MUX_ONLY    = 2'h1;
	localparam logic [1:0] MIX1_INPUT_ONLY  = 2'h2;
	localparam logic [1:0] MIX_POWERED_DOWN = 2'h3;
	localparam logic [1:0] MIX2_FILTER_ONLY = 2'h2;
	localparam logic [1:0] VOL_MUX_MIX2     = 2'h1;
	localparam logic [1:0] OUT_MUX_VOLUME   = 2'h0;
	localparam logic [1:0] OUT_AMP_SPK_HIGH = 2'h1;

	typedef enum logic [1:0] {
		APCB_RATE_8K0 = 2'h0,
		APCB_RATE_6K4 = 2'h1,
		APCB_RATE_5K3 = 2'h2,
		APCB_RATE_RSV = 2'h3
	} apcb_rate_t;

	// load sequence tracker, one-hot
	typedef enum logic [2:0] {
		APCB_WAIT_A = 3'h1,
		APCB_WAIT_B = 3'h2,
		APCB_WAIT_C = 3'h4
	} apcb_seq_t;

	// two-bit field of a word starting at bit lo
	function automatic logic [1:0] field2(input logic [15:0] w, input int lo);
		field2 = w[lo +: 2];
	endfunction

endpackage

/* File: hw/apcb_decoder.sv */
// decode of configuration words A and B into routing and power controls
`timescale 1ns/1ps
module apcb_decoder
	import apcb_pkg::*;
(
	// configuration words
	input  wire logic [15:0]       wordA,
	input  wire logic [15:0]       wordB,
	// routing
	output logic                   mix1MuxCodec,
	output logic                   mix1TakesMux,
	output logic                   mix1TakesInput,
	output logic                   mix1Powerdown,
	output logic                   filterFromArray,
	output logic                   mix2FilterOnly,
	output logic                   mix2Powerdown,
	output logic                   inputFromGainAmp,
	output logic                   volumeFromMix2,
	output logic                   outputFromVolume,
	// modes and power
	output logic                   compressionOn,
	output logic                   lowpassPowerdown,
	output apcb_rate_t             rateSel,
	output logic                   gainAmpPowerdown,
	output logic                   oscPowerdown,
	output logic                   attenuatorPowerdown,
	output logic [2:0]             attenuationStep,
	output logic [1:0]             outAmpMode,
	output logic                   speakerHighGain
);
	logic [1:0] mix1Src;
	logic [1:0] mix2Src;

	always_comb begin
		mix1Src             = field2(wordB, B_MIX1_SRC_LO);
		mix2Src             = field2(wordB, B_MIX2_SRC_LO);
		mix1Powerdown       = (mix1Src == MIX_POWERED_DOWN);
		mix2Powerdown       = (mix2Src == MIX_POWERED_DOWN);
		attenuatorPowerdown = wordA[A_ATTENUATOR_PD];
		// first mixer mux and volume select bits stay stored but are masked while their stage is off
		mix1MuxCodec     = !mix1Powerdown && field2(wordB, B_MIX1_MUX_LO) == MIX1_MUX_CODEC;
		mix1TakesMux     = (mix1Src == MIX1_MUX_ONLY);
		mix1TakesInput   = (mix1Src == MIX1_INPUT_ONLY);
		filterFromArray  = wordB[B_FILTER_SEL];
		mix2FilterOnly   = (mix2Src == MIX2_FILTER_ONLY);
		inputFromGainAmp = !wordA[A_INPUT_SRC] && !mix1Powerdown;
		volumeFromMix2   = !attenuatorPowerdown
			&& field2(wordB, B_VOL_MUX_LO) == VOL_MUX_MIX2;
		outputFromVolume = field2(wordA, A_OUTPUT_MUX_LO) == OUT_MUX_VOLUME;
		compressionOn    = wordA[A_COMPRESSION];
		lowpassPowerdown = wordB[B_LOWPASS_PD];
		rateSel          = apcb_rate_t'(field2(wordB, B_RATE_LO));
		gainAmpPowerdown = wordB[B_GAIN_AMP_PD];
		oscPowerdown     = wordA[A_OSC_PD];
		attenuationStep  = attenuatorPowerdown ? 3'h0 : wordB[B_ATTEN_LO +: 3];
		outAmpMode       = field2(wordA, A_OUT_AMP_LO);
		speakerHighGain  = (outAmpMode == OUT_AMP_SPK_HIGH);
	end

endmodule // apcb_decoder

/* File: hw/apcb_config_bank.sv */
// audio path configuration bank: words A and B staged, committed together with C, A and B decoded to controls
//
// Notes on behaviour
// - first mixer mux field is word B bits 9-10; zero routes the codec, except while word B bits 7-8 = 11 power the first mixer down.
// - first mixer source bits 7-8 of word B: 01 mux only, 10 input only.
// - word B bit 4 picks filter input: zero first mixer, one storage array.
// - word A bit 7 enables compression; zero disables it on record path.
// - word B bit 1 powers the low-pass filter down when one.
// - word B bits 2-3 pick rate: 00 8.0k, 01 6.4k, 10 5.3k.
// - word B bits 5-6 = 10 feeds only the filter into second mixer.
// - word B bit 0 zero powers up the automatic-gain amplifier.
// - word A bit 9 zero selects the gain amplifier as input source, unless word B bits 7-8 = 11 power the first mixer down.
// - word A bit 8 zero powers up the recorder oscillator.
// - word B bits 14-15 = 01 routes second mixer to volume stage, unless word A bit 0 powers the volume attenuator down.
// - word A bit 0 zero powers up the volume attenuator.
// - word B bits 11-13 give attenuation step, bit 11 least significant; the step reads zero while word A bit 0 is one.
// - word A bits 3-4 both zero route the volume stage to the outputs.
// - word A bits 1-2 = 01 gives high-gain speaker, auxiliary output off.
// - two of the three sixteen-bit configuration words, A and B, select all routing and power states.
`timescale 1ns/1ps
module apcb_config_bank
	import apcb_pkg::*;
(
	// clock and reset
	input  wire logic                 clk,
	input  wire logic                 rst,
	// word load strobe from the serial configuration engine
	input  wire logic                 loadValid,
	input  wire logic [1:0]           loadSel,
	input  wire logic [15:0]          loadData,
	// load status
	output logic                      orderFault,
	output logic                      commitPulse,
	output logic [1:0]                expectSel,
	// applied words for read-back
	output logic [15:0]               wordAOut,
	output logic [15:0]               wordBOut,
	output logic [15:0]               wordCOut,
	// routing controls
	output logic                      mix1MuxCodec,
	output logic                      mix1TakesMux,
	output logic                      mix1TakesInput,
	output logic                      mix1Powerdown,
	output logic                      filterFromArray,
	output logic                      mix2FilterOnly,
	output logic                      mix2Powerdown,
	output logic                      inputFromGainAmp,
	output logic                      volumeFromMix2,
	output logic                      outputFromVolume,
	// mode and power controls
	output logic                      compressionOn,
	output logic                      lowpassPowerdown,
	output apcb_pkg::apcb_rate_t      rateSel,
	output logic                      gainAmpPowerdown,
	output logic                      oscPowerdown,
	output logic                      attenuatorPowerdown,
	output logic [2:0]                attenuationStep,
	output logic [1:0]                outAmpMode,
	output logic                      speakerHighGain
);
	import apcb_pkg::*;

	// ==========================================================
	// load sequence
	apcb_seq_t   seq_reg;
	apcb_seq_t   seq_next;
	logic [15:0] stageA_reg;
	logic [15:0] stageB_reg;
	logic [15:0] wordA_reg;
	logic [15:0] wordB_reg;
	logic [15:0] wordC_reg;
	logic        fault_reg;
	logic        commit_reg;
	logic        takeA;
	logic        takeB;
	logic        takeC;
	logic        stray;

	// word A always restarts a load, so a host can recover from a broken one
	always_comb begin
		takeA = loadValid && loadSel == SEL_WORD_A;
		takeB = loadValid && loadSel == SEL_WORD_B && seq_reg == APCB_WAIT_B;
		takeC = loadValid && loadSel == SEL_WORD_C && seq_reg == APCB_WAIT_C;
		stray = loadValid && !takeA && !takeB && !takeC;
	end

	always_comb begin
		seq_next = seq_reg;
		case (seq_reg)
			APCB_WAIT_A: begin
				if (takeA) seq_next = APCB_WAIT_B;
			end
			APCB_WAIT_B: begin
				if (takeA) seq_next = APCB_WAIT_B;
				else if (takeB) seq_next = APCB_WAIT_C;
			end
			APCB_WAIT_C: begin
				if (takeA) seq_next = APCB_WAIT_B;
				else if (takeC) seq_next = APCB_WAIT_A;
			end
			default: seq_next = APCB_WAIT_A;
		endcase
	end

	always_ff @(posedge clk) begin
		if (rst) seq_reg <= APCB_WAIT_A;
		else seq_reg <= seq_next;
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			stageA_reg <= RST_WORD_A;
			stageB_reg <= RST_WORD_B;
		end else begin
			if (takeA) stageA_reg <= loadData;
			if (takeB) stageB_reg <= loadData;
		end
	end

	// out-of-order words are dropped; the fault holds until the next word A
	always_ff @(posedge clk) begin
		if (rst) fault_reg <= 1'b0;
		else if (stray) fault_reg <= 1'b1;
		else if (takeA) fault_reg <= 1'b0;
	end

	// ==========================================================
	// applied words: all three change on one edge so the path never glitches
	always_ff @(posedge clk) begin
		if (rst) begin
			wordA_reg <= RST_WORD_A;
			wordB_reg <= RST_WORD_B;
			wordC_reg <= RST_WORD_C;
		end else if (takeC) begin
			wordA_reg <= stageA_reg;
			wordB_reg <= stageB_reg;
			wordC_reg <= loadData;
		end
	end

	always_ff @(posedge clk) begin
		if (rst) commit_reg <= 1'b0;
		else commit_reg <= takeC;
	end

	// ==========================================================
	// decode, registered on every edge so controls come from flip-flops; on commit the staged words are decoded
	logic       dMix1MuxCodec;
	logic       dMix1TakesMux;
	logic       dMix1TakesInput;
	logic       dMix1Powerdown;
	logic       dFilterFromArray;
	logic       dMix2FilterOnly;
	logic       dMix2Powerdown;
	logic       dInputFromGainAmp;
	logic       dVolumeFromMix2;
	logic       dOutputFromVolume;
	logic       dCompressionOn;
	logic       dLowpassPowerdown;
	apcb_rate_t dRateSel;
	logic       dGainAmpPowerdown;
	logic       dOscPowerdown;
	logic       dAttenuatorPowerdown;
	logic [2:0] dAttenuationStep;
	logic [1:0] dOutAmpMode;
	logic       dSpeakerHighGain;
	logic [15:0] decA;
	logic [15:0] decB;

	// before the first commit the reset words are decoded
	always_comb begin
		decA = takeC ? stageA_reg : wordA_reg;
		decB = takeC ? stageB_reg : wordB_reg;
	end

	apcb_decoder u_decoder (
		.wordA               (decA),
		.wordB               (decB),
		.mix1MuxCodec        (dMix1MuxCodec),
		.mix1TakesMux        (dMix1TakesMux),
		.mix1TakesInput      (dMix1TakesInput),
		.mix1Powerdown       (dMix1Powerdown),
		.filterFromArray     (dFilterFromArray),
		.mix2FilterOnly      (dMix2FilterOnly),
		.mix2Powerdown       (dMix2Powerdown),
		.inputFromGainAmp    (dInputFromGainAmp),
		.volumeFromMix2      (dVolumeFromMix2),
		.outputFromVolume    (dOutputFromVolume),
		.compressionOn       (dCompressionOn),
		.lowpassPowerdown    (dLowpassPowerdown),
		.rateSel             (dRateSel),
		.gainAmpPowerdown    (dGainAmpPowerdown),
		.oscPowerdown        (dOscPowerdown),
		.attenuatorPowerdown (dAttenuatorPowerdown),
		.attenuationStep     (dAttenuationStep),
		.outAmpMode          (dOutAmpMode),
		.speakerHighGain     (dSpeakerHighGain)
	);

	// reset value comes through the decoder, so rst only forces a reload
	always_ff @(posedge clk) begin
		mix1MuxCodec        <= dMix1MuxCodec;
		mix1TakesMux        <= dMix1TakesMux;
		mix1TakesInput      <= dMix1TakesInput;
		mix1Powerdown       <= dMix1Powerdown;
		filterFromArray     <= dFilterFromArray;
		mix2FilterOnly      <= dMix2FilterOnly;
		mix2Powerdown       <= dMix2Powerdown;
		inputFromGainAmp    <= dInputFromGainAmp;
		volumeFromMix2      <= dVolumeFromMix2;
		outputFromVolume    <= dOutputFromVolume;
		compressionOn       <= dCompressionOn;
		lowpassPowerdown    <= dLowpassPowerdown;
		rateSel             <= dRateSel;
		gainAmpPowerdown    <= dGainAmpPowerdown;
		oscPowerdown        <= dOscPowerdown;
		attenuatorPowerdown <= dAttenuatorPowerdown;
		attenuationStep     <= dAttenuationStep;
		outAmpMode          <= dOutAmpMode;
		speakerHighGain     <= dSpeakerHighGain;
	end

	// ==========================================================
	// outputs
	always_comb begin
		wordAOut    = wordA_reg;
		wordBOut    = wordB_reg;
		wordCOut    = wordC_reg;
		orderFault  = fault_reg;
		commitPulse = commit_reg;
		case (seq_reg)
			APCB_WAIT_B: expectSel = SEL_WORD_B;
			APCB_WAIT_C: expectSel = SEL_WORD_C;
			default:     expectSel = SEL_WORD_A;
		endcase
	end

	// ==========================================================
	// checks
	default clocking cb @(posedge clk); endclocking
	default disable iff (rst);

	sequence loadAthenB;
		loadValid && loadSel == SEL_WORD_A ##1 loadValid && loadSel == SEL_WORD_B;
	endsequence

	sequence loadC;
		loadValid && loadSel == SEL_WORD_C;
	endsequence

	full_load_commit_a: assert property (
		loadAthenB ##1 loadC |=> commitPulse && wordCOut == $past(loadData))
		else $error("ordered load did not commit");
	stray_word_fault_a: assert property (
		seq_reg == APCB_WAIT_A && loadValid && loadSel == SEL_WORD_C |=> orderFault && !commitPulse)
		else $error("out of order word not flagged");
	codec_route_a: assert property (
		commitPulse && wordBOut[10:9] == 2'h0 && wordBOut[8:7] != 2'h3 |=> mix1MuxCodec)
		else $error("codec not routed to first mixer");
	mix1_src_a: assert property (
		commitPulse |=> mix1TakesMux == ($past(wordBOut[8:7]) == 2'h1)
			&& mix1TakesInput == ($past(wordBOut[8:7]) == 2'h2))
		else $error("first mixer source decode wrong");
	filter_sel_a: assert property (
		commitPulse |=> filterFromArray == $past(wordBOut[4]))
		else $error("filter input select wrong");
	compression_off_a: assert property (
		commitPulse && !wordAOut[7] |=> !compressionOn [*2])
		else $error("compression not disabled");
	power_bits_a: assert property (
		commitPulse |=> lowpassPowerdown == $past(wordBOut[1]) && gainAmpPowerdown == $past(wordBOut[0])
			&& oscPowerdown == $past(wordAOut[8]) && attenuatorPowerdown == $past(wordAOut[0]))
		else $error("power-down bit decode wrong");
	rate_sel_a: assert property (
		commitPulse && wordBOut[3:2] == 2'h1 |=> rateSel == APCB_RATE_6K4)
		else $error("6.4 kHz rate not selected");
	mix2_filter_a: assert property (
		commitPulse && wordBOut[6:5] == 2'h2 |=> mix2FilterOnly && !mix2Powerdown)
		else $error("second mixer filter path wrong");
	volume_step_a: assert property (
		commitPulse && !wordAOut[0] && wordBOut[15:11] == 5'h0B |=> volumeFromMix2 && attenuationStep == 3'h3)
		else $error("volume route or step wrong");
	speaker_high_a: assert property (
		commitPulse && wordAOut[2:1] == 2'h1 && wordAOut[4:3] == 2'h0 |=> speakerHighGain && outputFromVolume)
		else $error("speaker high gain path wrong");
	words_hold_a: assert property (
		!commitPulse && !$past(takeC) && !$past(rst)
			|-> $stable(wordAOut) && $stable(wordBOut) && $stable(wordCOut))
		else $error("applied word changed without commit");

endmodule // apcb_config_bank

/* File: verification/apcb_host_model.sv */
// host stand-in that loads configuration words through the load strobe
`timescale 1ns/1ps
module apcb_host_model (
	// clock
	input  wire logic        clk,
	// load strobe towards the bank
	output logic             loadValid,
	output logic [1:0]       loadSel,
	output logic [15:0]      loadData
);
	initial begin
		loadValid = 1'h0;
		loadSel   = 2'h0;
		loadData  = 16'h0000;
	end

	// ==========================================================
	// bus cycles, driven at the falling edge
	task automatic put(input logic [1:0] sel, input logic [15:0] data);
		@(negedge clk);
		loadValid = 1'h1;
		loadSel   = sel;
		loadData  = data;
	endtask

	// released lines do not keep the last value, so stale data cannot pass
	task automatic release_bus();
		@(negedge clk);
		loadValid = 1'h0;
		loadSel   = ~loadSel;
		loadData  = ~loadData;
	endtask

	task automatic load_set(input logic [15:0] a, input logic [15:0] b, input logic [15:0] c);
		put(2'h0, a);
		put(2'h1, b);
		put(2'h2, c);
		release_bus();
	endtask
endmodule // apcb_host_model

/* File: verification/test_audio_path_config_bank.sv */
// self-checking bench of the audio path configuration bank
`timescale 1ns/1ps
`define CHK(name, exp, act) begin checksDone++; if ((act) !== (exp)) begin mismatches++; $display("Error %s expected %h seen %h", name, exp, act); end end
module test_audio_path_config_bank import apcb_pkg::*;;
	// ==========================================================
	// signals
	logic              clk = 1'h0;
	logic              rst = 1'h1;
	logic              loadValid, orderFault, commitPulse;
	logic [1:0]        loadSel, expectSel, outAmpMode;
	logic [15:0]       loadData, wordAOut, wordBOut, wordCOut, expA, expB, expC, x, y, z;
	logic              mix1MuxCodec, mix1TakesMux, mix1TakesInput, mix1Powerdown, filterFromArray;
	logic              mix2FilterOnly, mix2Powerdown, inputFromGainAmp, volumeFromMix2, outputFromVolume;
	logic              compressionOn, lowpassPowerdown, gainAmpPowerdown, oscPowerdown, attenuatorPowerdown;
	logic              speakerHighGain;
	logic [2:0]        attenuationStep;
	apcb_rate_t        rateSel;
	logic [31:0]       seed = 32'hD73E;
	logic [15:0]       modeTab [0:17];
	int                mismatches = 0;
	int                checksDone = 0;

	always #5 clk = ~clk;

	apcb_host_model host (.clk(clk), .loadValid(loadValid), .loadSel(loadSel), .loadData(loadData));

	apcb_config_bank dut (.clk(clk), .rst(rst), .loadValid(loadValid), .loadSel(loadSel), .loadData(loadData),
		.orderFault(orderFault), .commitPulse(commitPulse), .expectSel(expectSel),
		.wordAOut(wordAOut), .wordBOut(wordBOut), .wordCOut(wordCOut),
		.mix1MuxCodec(mix1MuxCodec), .mix1TakesMux(mix1TakesMux), .mix1TakesInput(mix1TakesInput),
		.mix1Powerdown(mix1Powerdown), .filterFromArray(filterFromArray), .mix2FilterOnly(mix2FilterOnly),
		.mix2Powerdown(mix2Powerdown), .inputFromGainAmp(inputFromGainAmp), .volumeFromMix2(volumeFromMix2),
		.outputFromVolume(outputFromVolume), .compressionOn(compressionOn), .lowpassPowerdown(lowpassPowerdown),
		.rateSel(rateSel), .gainAmpPowerdown(gainAmpPowerdown), .oscPowerdown(oscPowerdown),
		.attenuatorPowerdown(attenuatorPowerdown), .attenuationStep(attenuationStep),
		.outAmpMode(outAmpMode), .speakerHighGain(speakerHighGain));

	// ==========================================================
	// helpers
	function automatic logic [31:0] lfsr(input logic [31:0] s);
		lfsr = {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction

	task automatic draw(output logic [15:0] v);
		seed = lfsr(seed);
		v = seed[15:0];
	endtask

	task automatic check_all();
		`CHK("wordAOut", expA, wordAOut)
		`CHK("wordBOut", expB, wordBOut)
		`CHK("wordCOut", expC, wordCOut)
		`CHK("mix1MuxCodec", (expB[10:9] == 2'h0) && (expB[8:7] != 2'h3), mix1MuxCodec)
		`CHK("mix1TakesMux", expB[8:7] == 2'h1, mix1TakesMux)
		`CHK("mix1TakesInput", expB[8:7] == 2'h2, mix1TakesInput)
		`CHK("mix1Powerdown", expB[8:7] == 2'h3, mix1Powerdown)
		`CHK("filterFromArray", expB[4], filterFromArray)
		`CHK("compressionOn", expA[7], compressionOn)
		`CHK("lowpassPowerdown", expB[1], lowpassPowerdown)
		`CHK("rateSel", apcb_rate_t'(expB[3:2]), rateSel)
		`CHK("mix2FilterOnly", expB[6:5] == 2'h2, mix2FilterOnly)
		`CHK("mix2Powerdown", expB[6:5] == 2'h3, mix2Powerdown)
		`CHK("gainAmpPowerdown", expB[0], gainAmpPowerdown)
		`CHK("inputFromGainAmp", !expA[9] && (expB[8:7] != 2'h3), inputFromGainAmp)
		`CHK("oscPowerdown", expA[8], oscPowerdown)
		`CHK("volumeFromMix2", (expB[15:14] == 2'h1) && !expA[0], volumeFromMix2)
		`CHK("attenuatorPowerdown", expA[0], attenuatorPowerdown)
		`CHK("attenuationStep", expA[0] ? 3'h0 : expB[13:11], attenuationStep)
		`CHK("outputFromVolume", expA[4:3] == 2'h0, outputFromVolume)
		`CHK("outAmpMode", expA[2:1], outAmpMode)
		`CHK("speakerHighGain", expA[2:1] == 2'h1, speakerHighGain)
	endtask

	// full three-word load, committed as one set
	task automatic apply(input logic [15:0] a, input logic [15:0] b, input logic [15:0] c);
		host.load_set(a, b, c);
		`CHK("commitPulse", 1'h1, commitPulse)
		expA = a;
		expB = b;
		expC = c;
		check_all();
		@(negedge clk);
		`CHK("commitPulse", 1'h0, commitPulse)
		`CHK("orderFault", 1'h0, orderFault)
		`CHK("expectSel", 2'h0, expectSel)
	endtask

	task automatic conclude();
		if (mismatches == 0 && checksDone > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask

	// ==========================================================
	// main sequence
	initial begin
		// feed-through, call record, memo record, playback, then all-zero and all-one corners
		modeTab = '{16'h254B, 16'h01E3, 16'h0040, 16'h440B, 16'h00C5, 16'h0040, 16'h0401, 16'h0148, 16'h0003,
			16'h2422, 16'h59D1, 16'h0003, 16'h0000, 16'h0000, 16'h0000, 16'hFFFF, 16'hFFFF, 16'hFFFF};
		repeat (8) @(posedge clk);
		@(negedge clk);
		rst = 1'h0;
		expA = 16'h0101;
		expB = 16'h0183;
		expC = 16'h0000;
		check_all();
		`CHK("expectSel", 2'h0, expectSel)
		for (int i = 0; i < 6; i++) begin
			apply(modeTab[3 * i], modeTab[3 * i + 1], modeTab[3 * i + 2]);
		end
		// partial set must not reach the outputs
		draw(x);
		draw(y);
		host.put(2'h0, x);
		host.put(2'h1, y);
		host.release_bus();
		`CHK("expectSel", 2'h2, expectSel)
		`CHK("commitPulse", 1'h0, commitPulse)
		check_all();
		// stray word B while waiting for C is dropped, then C commits the staged set
		host.put(2'h1, ~y);
		host.release_bus();
		@(negedge clk);
		`CHK("orderFault", 1'h1, orderFault)
		`CHK("expectSel", 2'h2, expectSel)
		draw(z);
		host.put(2'h2, z);
		host.release_bus();
		expA = x;
		expB = y;
		expC = z;
		check_all();
		`CHK("orderFault", 1'h1, orderFault)
		// stray word C while idle is refused, then an unmapped index as well
		apply(16'h2422, 16'h59D1, 16'h0003);
		host.put(2'h2, 16'h5A5A);
		host.release_bus();
		@(negedge clk);
		`CHK("orderFault", 1'h1, orderFault)
		`CHK("commitPulse", 1'h0, commitPulse)
		check_all();
		apply(16'h2422, 16'h59D1, 16'h0003);
		host.put(2'h3, 16'hA5A5);
		host.release_bus();
		@(negedge clk);
		`CHK("orderFault", 1'h1, orderFault)
		check_all();
		// word A mid-sequence restarts, back to back
		host.put(2'h0, 16'h0401);
		host.put(2'h1, 16'h0148);
		apply(16'h440B, 16'h00C5, 16'h0040);
		for (int i = 0; i < 40; i++) begin
			draw(x);
			draw(y);
			draw(z);
			apply(x, y, z);
		end
		// reset in the middle of a sequence restores the power-down set
		host.put(2'h0, x);
		host.put(2'h1, y);
		host.release_bus();
		rst = 1'h1;
		// decoded controls pick up the reset words one edge after the words
		repeat (2) @(negedge clk);
		rst = 1'h0;
		`CHK("commitPulse", 1'h0, commitPulse)
		expA = 16'h0101;
		expB = 16'h0183;
		expC = 16'h0000;
		check_all();
		`CHK("expectSel", 2'h0, expectSel)
		`CHK("orderFault", 1'h0, orderFault)
		apply(16'h254B, 16'h01E3, 16'h0040);
		conclude();
	end

	// the whole run needs well under two thousand cycles
	initial begin
		#200000;
		mismatches++;
		conclude();
	end
endmodule // test_audio_path_config_bank
